// >>> rtl/flash_guard_pkg.sv
// Constants shared by the serial flash protection and framing logic.
// How it works
// - Bottom select clear: level 1,2,3 guards top 1,2,4 blocks; 4 and up guards all.
// - Bottom select set: same sizes counted from block 0; level 0 guards none.
// - Whole-chip erase runs only when all four protect level bits are zero.
// - A separate 8K-bit OTP area of two independently lockable 4K-bit rows.
// - Customer row sits at offsets 000-1FF, factory row at 200-3FF.
// - Security byte bit 0 shows the factory lock of the second row.
// - Security write command sets security byte bit 1, locking the customer row.
// - OTP programming: enter OTP mode, normal program, then exit OTP mode.
// - A locked OTP row refuses every later change, for good.
// - While OTP mode is on, the main array cannot be reached.
// - Unknown opcode: standby, output undriven, until next chip select fall.
// - Known opcode: active until the next chip select rise.
// - Bits are taken on serial clock rise and driven out on its fall.
// - Clock idling low or high both work with the same edges.
// - Read-type commands stream data out; host may end after any bit.
// - Change-type commands must end on a byte boundary or are dropped.
// - While an operation is busy, array accesses are ignored.
// - Data-changing commands need the write enable latch set first.
// - Write-protect pin guards protect bits and guard bit, unless in quad modes.
package flash_guard_pkg;

    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [7:0] PAGE_PROG_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
    localparam logic [7:0] HALF_BLOCK_ERASE_CMD = 8'h52;
    localparam logic [7:0] BLOCK_ERASE_CMD = 8'hD8;
    localparam logic [7:0] CHIP_ERASE_CMD_A = 8'h60;
    localparam logic [7:0] CHIP_ERASE_CMD_B = 8'hC7;
    localparam logic [7:0] NOP_CMD = 8'h00;
    localparam logic [7:0] STATUS_REG_WRITE_CMD = 8'h01;
    localparam logic [7:0] STATUS_REG_READ_CMD = 8'h05;
    localparam logic [7:0] OTP_MODE_ENTER_CMD = 8'hB1;
    localparam logic [7:0] OTP_MODE_EXIT_CMD = 8'hC1;
    localparam logic [7:0] SECURITY_REG_WRITE_CMD = 8'h2F;
    localparam logic [7:0] SECURITY_REG_READ_CMD = 8'h2B;

    // ****************************************
    // Field positions and sizes
    // ****************************************
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WEL_BIT = 1;
    localparam int STAT_LEVEL_LSB = 2;
    localparam int STAT_GUARD_BIT = 7;
    localparam int SEC_FACTORY_BIT = 0;
    localparam int SEC_CUSTOMER_BIT = 1;
    localparam int BLOCK_LSB = 16;
    localparam int BLOCK_MSB = 18;
    localparam int BLOCK_COUNT = 8;
    localparam int OTP_ROW_BIT = 9;
    localparam logic [3:0] LEVEL_ALL = 4'h4;
    localparam logic [2:0] BYTES_ADDR_END = 3'h4;
    localparam logic [2:0] BYTES_ONE = 3'h1;
    localparam logic [2:0] BYTES_TWO = 3'h2;
    localparam logic [2:0] BYTES_SAT = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [23:0] ADDR_RESET = 24'h000000;

    typedef enum logic [1:0] {
        FRAME_IDLE,
        FRAME_CMD,
        FRAME_ACTIVE,
        FRAME_IGNORE
    } frame_e;

endpackage : flash_guard_pkg

// >>> rtl/protect_decode.sv
// Decoder from protect level and bottom select to a per-block guard mask.
module protect_decode (
    input wire logic [3:0] level_i,
    input wire logic top_bottom_select_i,
    output logic [flash_guard_pkg::BLOCK_COUNT-1:0] mask_o
);

    // ****************************************
    // Guarded block count
    // ****************************************
    // Level 3 jumps to four blocks, so this is not a plain binary count
    logic [3:0] count;
    assign count = (level_i >= flash_guard_pkg::LEVEL_ALL) ? 4'h8 :
                   (level_i == 4'h3) ? 4'h4 :
                   level_i;

    // ****************************************
    // Per-block compare
    // ****************************************
    genvar b;
    generate
        for (b = 0; b < flash_guard_pkg::BLOCK_COUNT; b++) begin : g_blk
            // Top mode counts down from block 7, bottom mode up from block 0
            assign mask_o[b] = top_bottom_select_i ? (4'(b) < count) :
                               (4'(7 - b) < count);
        end
    endgenerate

endmodule : protect_decode

// >>> rtl/flash_guard.sv
// Serial command framing, write guarding and OTP locking of a serial flash.
module flash_guard (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic wp_n_i,
    input wire logic quad_mode_i,
    input wire logic top_bottom_select_i,
    input wire logic busy_i,
    input wire logic factory_lock_i,
    input wire logic [7:0] rd_data_i,
    output logic rd_strobe_o,
    output logic [23:0] rd_addr_o,
    output logic wr_byte_o,
    output logic [7:0] wr_data_o,
    output logic exec_o,
    output logic [7:0] exec_cmd_o,
    output logic [23:0] exec_addr_o,
    output logic reject_o,
    output logic [3:0] protect_level_o,
    output logic guard_bit_o,
    output logic write_enable_latch_o,
    output logic customer_lock_o,
    output logic otp_mode_o
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] cs_sync, sclk_sync, si_sync, wp_sync;
    logic cs_d, sclk_d;

    // Every pin passes two flops; edge detectors look only at stage two
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_sync <= 2'h3;
            sclk_sync <= 2'h0;
            si_sync <= 2'h0;
            wp_sync <= 2'h3;
            cs_d <= 1'b1;
            sclk_d <= 1'b0;
        end else begin
            cs_sync <= {cs_sync[0], cs_n_i};
            sclk_sync <= {sclk_sync[0], sclk_i};
            si_sync <= {si_sync[0], si_i};
            wp_sync <= {wp_sync[0], wp_n_i};
            cs_d <= cs_sync[1];
            sclk_d <= sclk_sync[1];
        end
    end

    logic cs_fall, cs_rise, in_frame, sck_rise, sck_fall;
    assign cs_fall = cs_d && !cs_sync[1];
    assign cs_rise = !cs_d && cs_sync[1];
    assign in_frame = !cs_sync[1];
    // Edges are judged from the line itself, so idle level does not matter
    assign sck_rise = in_frame && !sclk_d && sclk_sync[1];
    assign sck_fall = in_frame && sclk_d && !sclk_sync[1];

    // ****************************************
    // State
    // ****************************************
    flash_guard_pkg::frame_e state;
    logic [2:0] bit_cnt, byte_cnt;
    logic [7:0] in_sr, out_sr, opcode;
    logic [23:0] addr;
    logic dout, rd_load, write_enable_latch, cust_lock, otp_mode, guard;
    logic [3:0] level;
    logic [7:0] data_byte;

    // ****************************************
    // Decode
    // ****************************************
    logic [7:0] next_in;
    logic byte_done;
    assign next_in = {in_sr[6:0], si_sync[1]};
    assign byte_done = sck_rise && (bit_cnt == flash_guard_pkg::BIT_LAST);

    logic is_read, is_stat, is_sec, is_pp, is_erase, is_ce, is_simple, is_status_reg_write_cmd, is_security_reg_write_cmd;
    assign is_read = (next_in == flash_guard_pkg::READ_CMD);
    assign is_stat = (next_in == flash_guard_pkg::STATUS_REG_READ_CMD);
    assign is_sec = (next_in == flash_guard_pkg::SECURITY_REG_READ_CMD);
    assign is_pp = (opcode == flash_guard_pkg::PAGE_PROG_CMD);
    assign is_erase = (opcode == flash_guard_pkg::SECTOR_ERASE_CMD) ||
                      (opcode == flash_guard_pkg::HALF_BLOCK_ERASE_CMD) ||
                      (opcode == flash_guard_pkg::BLOCK_ERASE_CMD);
    assign is_ce = (opcode == flash_guard_pkg::CHIP_ERASE_CMD_A) ||
                   (opcode == flash_guard_pkg::CHIP_ERASE_CMD_B);
    assign is_simple = (opcode == flash_guard_pkg::WRITE_ENABLE_CMD) ||
                       (opcode == flash_guard_pkg::WRITE_DISABLE_CMD) ||
                       (opcode == flash_guard_pkg::OTP_MODE_ENTER_CMD) ||
                       (opcode == flash_guard_pkg::OTP_MODE_EXIT_CMD) ||
                       (opcode == flash_guard_pkg::NOP_CMD);
    assign is_status_reg_write_cmd = (opcode == flash_guard_pkg::STATUS_REG_WRITE_CMD);
    assign is_security_reg_write_cmd = (opcode == flash_guard_pkg::SECURITY_REG_WRITE_CMD);

    // Opcode recognition on the incoming byte
    logic known;
    assign known = is_read || is_stat || is_sec ||
                   (next_in == flash_guard_pkg::PAGE_PROG_CMD) ||
                   (next_in == flash_guard_pkg::SECTOR_ERASE_CMD) ||
                   (next_in == flash_guard_pkg::HALF_BLOCK_ERASE_CMD) ||
                   (next_in == flash_guard_pkg::BLOCK_ERASE_CMD) ||
                   (next_in == flash_guard_pkg::CHIP_ERASE_CMD_A) ||
                   (next_in == flash_guard_pkg::CHIP_ERASE_CMD_B) ||
                   (next_in == flash_guard_pkg::WRITE_ENABLE_CMD) ||
                   (next_in == flash_guard_pkg::WRITE_DISABLE_CMD) ||
                   (next_in == flash_guard_pkg::OTP_MODE_ENTER_CMD) ||
                   (next_in == flash_guard_pkg::OTP_MODE_EXIT_CMD) ||
                   (next_in == flash_guard_pkg::NOP_CMD) ||
                   (next_in == flash_guard_pkg::STATUS_REG_WRITE_CMD) ||
                   (next_in == flash_guard_pkg::SECURITY_REG_WRITE_CMD);

    // Status and security bytes as the host reads them
    logic [7:0] stat_byte, sec_byte;
    assign stat_byte = {guard, 1'b0, level, write_enable_latch, busy_i};
    assign sec_byte = {6'h00, cust_lock, factory_lock_i};

    // ****************************************
    // Protection checks
    // ****************************************
    logic [7:0] block_mask;
    protect_decode u_decode (
        .level_i(level),
        .top_bottom_select_i(top_bottom_select_i),
        .mask_o(block_mask)
    );

    logic prot_hit, row_locked, pin_guard;
    assign prot_hit = block_mask[addr[flash_guard_pkg::BLOCK_MSB:
                                      flash_guard_pkg::BLOCK_LSB]];
    // Row picked by offset bit 9: low half customer, high half factory
    assign row_locked = addr[flash_guard_pkg::OTP_ROW_BIT] ? factory_lock_i :
                        cust_lock;
    assign pin_guard = guard && !wp_sync[1] && !quad_mode_i;

    // Framing check at chip select rise: whole bytes only, no open read
    logic frame_ok, len_ok, accept;
    assign frame_ok = cs_rise && (state == flash_guard_pkg::FRAME_ACTIVE) &&
                      (bit_cnt == 3'h0) && !dout;
    assign len_ok = is_pp ? (byte_cnt > flash_guard_pkg::BYTES_ADDR_END) :
                    is_erase ? (byte_cnt == flash_guard_pkg::BYTES_ADDR_END) :
                    is_status_reg_write_cmd ? (byte_cnt == flash_guard_pkg::BYTES_TWO) :
                    (byte_cnt == flash_guard_pkg::BYTES_ONE);
    // Change commands need the latch and an idle engine
    logic may_change;
    assign may_change = write_enable_latch && !busy_i;
    assign accept = frame_ok && len_ok && (
        is_simple ||
        (is_pp && may_change && (otp_mode ? !row_locked : !prot_hit)) ||
        (is_erase && may_change && !otp_mode && !prot_hit) ||
        (is_ce && may_change && !otp_mode && (level == 4'h0)) ||
        (is_status_reg_write_cmd && may_change && !pin_guard) ||
        (is_security_reg_write_cmd && may_change));

    logic changes;
    assign changes = is_pp || is_erase || is_ce || is_status_reg_write_cmd || is_security_reg_write_cmd;

    // ****************************************
    // Frame sequencing
    // ****************************************
    // A frame always restarts on chip select fall, even from ignore
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= flash_guard_pkg::FRAME_IDLE;
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            in_sr <= 8'h00;
            opcode <= 8'h00;
            dout <= 1'b0;
        end else if (cs_fall) begin
            state <= flash_guard_pkg::FRAME_CMD;
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            dout <= 1'b0;
        end else if (!in_frame) begin
            state <= flash_guard_pkg::FRAME_IDLE;
            dout <= 1'b0;
        end else if (sck_rise && state != flash_guard_pkg::FRAME_IGNORE) begin
            in_sr <= next_in;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done && byte_cnt != flash_guard_pkg::BYTES_SAT) begin
                byte_cnt <= byte_cnt + 3'h1;
            end
            if (byte_done) begin
                case (state)
                    flash_guard_pkg::FRAME_CMD: begin
                        opcode <= next_in;
                        state <= known ? flash_guard_pkg::FRAME_ACTIVE :
                                 flash_guard_pkg::FRAME_IGNORE;
                        dout <= known && (is_stat || is_sec);
                    end
                    flash_guard_pkg::FRAME_ACTIVE: begin
                        // Reads start driving after the third address byte
                        if (opcode == flash_guard_pkg::READ_CMD &&
                            byte_cnt == 3'h3) begin
                            dout <= 1'b1;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Address, data and read fetch
    // ****************************************
    // Fetch is issued one cycle after the byte ends, data loads one later
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr <= flash_guard_pkg::ADDR_RESET;
            data_byte <= 8'h00;
            rd_strobe_o <= 1'b0;
            rd_load <= 1'b0;
            wr_byte_o <= 1'b0;
        end else begin
            rd_strobe_o <= 1'b0;
            wr_byte_o <= 1'b0;
            rd_load <= rd_strobe_o;
            if (byte_done && state == flash_guard_pkg::FRAME_ACTIVE) begin
                // Status write has no address, its data byte follows the opcode
                if (is_status_reg_write_cmd || byte_cnt >= flash_guard_pkg::BYTES_ADDR_END) begin
                    data_byte <= next_in;
                end else if (byte_cnt >= 3'h1 && byte_cnt <= 3'h3) begin
                    addr <= {addr[15:0], next_in};
                end
                if (opcode == flash_guard_pkg::READ_CMD && byte_cnt >= 3'h3) begin
                    rd_strobe_o <= !busy_i;
                end
                if (is_pp && byte_cnt >= flash_guard_pkg::BYTES_ADDR_END) begin
                    wr_byte_o <= 1'b1;
                end
            end
            // Program and reads step through the address after each byte
            if (rd_strobe_o || wr_byte_o) begin
                addr[7:0] <= addr[7:0] + 8'h01;
                if (rd_strobe_o) begin
                    addr[23:8] <= addr[23:8] + {15'h0000, (addr[7:0] == 8'hFF)};
                end
            end
        end
    end

    assign rd_addr_o = addr;
    assign wr_data_o = data_byte;

    // ****************************************
    // Serial output
    // ****************************************
    // Loads land between rise and the following fall, ahead of first bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_sr <= 8'h00;
            so_o <= 1'b0;
        end else if (byte_done && state == flash_guard_pkg::FRAME_CMD) begin
            out_sr <= is_sec ? sec_byte : stat_byte;
        end else if (rd_load) begin
            out_sr <= busy_i ? 8'h00 : rd_data_i;
        end else if (sck_fall && dout) begin
            so_o <= out_sr[7];
            out_sr <= (opcode == flash_guard_pkg::READ_CMD) ? {out_sr[6:0], 1'b0} :
                      {out_sr[6:0], out_sr[7]};
        end
    end

    // Output stays undriven in standby and after unknown opcodes
    assign so_oe_o = dout && in_frame && (state == flash_guard_pkg::FRAME_ACTIVE);

    // ****************************************
    // Latches, protect bits and OTP locks
    // ****************************************
    // The customer lock has no clear path; only power loss models it away
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_enable_latch <= 1'b0;
            level <= flash_guard_pkg::LEVEL_RESET;
            guard <= 1'b0;
            cust_lock <= 1'b0;
            otp_mode <= 1'b0;
        end else if (accept) begin
            if (opcode == flash_guard_pkg::WRITE_ENABLE_CMD) begin
                write_enable_latch <= 1'b1;
            end else if (opcode == flash_guard_pkg::WRITE_DISABLE_CMD || changes) begin
                write_enable_latch <= 1'b0;
            end
            if (opcode == flash_guard_pkg::OTP_MODE_ENTER_CMD) begin
                otp_mode <= 1'b1;
            end
            if (opcode == flash_guard_pkg::OTP_MODE_EXIT_CMD) begin
                otp_mode <= 1'b0;
            end
            if (is_status_reg_write_cmd) begin
                level <= data_byte[flash_guard_pkg::STAT_LEVEL_LSB +: 4];
                guard <= data_byte[flash_guard_pkg::STAT_GUARD_BIT];
            end
            if (is_security_reg_write_cmd) begin
                cust_lock <= 1'b1;
            end
        end
    end

    // ****************************************
    // Execute and reject pulses
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exec_o <= 1'b0;
            reject_o <= 1'b0;
            exec_cmd_o <= 8'h00;
            exec_addr_o <= flash_guard_pkg::ADDR_RESET;
        end else begin
            exec_o <= accept && (is_pp || is_erase || is_ce);
            reject_o <= cs_rise && (state == flash_guard_pkg::FRAME_ACTIVE) &&
                        !accept && !dout;
            if (accept) begin
                exec_cmd_o <= opcode;
                exec_addr_o <= addr;
            end
        end
    end

    assign protect_level_o = level;
    assign guard_bit_o = guard;
    assign write_enable_latch_o = write_enable_latch;
    assign customer_lock_o = cust_lock;
    assign otp_mode_o = otp_mode;

endmodule : flash_guard

// >>> tb/spi_host.sv
// Behavioural serial host that frames commands towards the flash guard.
module spi_host (
    input wire logic clk_i,
    input wire logic so_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic mode3 = 1'b0;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    // Half of the 80 ns link period, always ending just after a clock edge
    task automatic half();
        repeat (4) @(posedge clk_i);
        #1;
    endtask : half
    // Drive while low, take the answer at the rise
    task automatic shift(input logic [55:0] b, input int nb, output logic [55:0] rx);
        rx = '0;
        for (int i = 0; i < nb; i++) begin
            sclk_o = 1'b0;
            si_o = b[55-i];
            half();
            sclk_o = 1'b1;
            rx = {rx[54:0], so_i};
            half();
        end
    endtask : shift
    // Clock idles at the mode level; the count may stop mid-byte
    task automatic frame(input logic [55:0] b, input int nb, output logic [55:0] rx);
        sclk_o = mode3;
        half();
        cs_n_o = 1'b0;
        half();
        shift(b, nb, rx);
        sclk_o = mode3;
        half();
        cs_n_o = 1'b1;
        si_o = ~si_o; // Released line must not keep its last value
        half();
        half();
    endtask : frame
endmodule : spi_host

// >>> tb/flash_guard_checker.sv
// Port-level assertions for the flash guard.
module flash_guard_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic busy_i,
    input wire logic top_bottom_select_i,
    input wire logic so_oe_o,
    input wire logic exec_o,
    input wire logic [7:0] exec_cmd_o,
    input wire logic [23:0] exec_addr_o,
    input wire logic [3:0] protect_level_o,
    input wire logic write_enable_latch_o,
    input wire logic customer_lock_o,
    input wire logic otp_mode_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic [2:0] cs_high;
    logic [3:0] span;
    logic hit;
    logic chip;
    // Guarded block count and whether the executed address lands in it
    assign span = protect_level_o > 4'h3 ? 4'h8 : (protect_level_o == 4'h3 ? 4'h4 : protect_level_o);
    assign hit = top_bottom_select_i ? {1'b0, exec_addr_o[18:16]} < span :
        {1'b0, exec_addr_o[18:16]} >= 4'h8 - span;
    assign chip = exec_cmd_o == flash_guard_pkg::CHIP_ERASE_CMD_A ||
        exec_cmd_o == flash_guard_pkg::CHIP_ERASE_CMD_B;
    // Saturating count of chip select high, covering the pin synchroniser delay
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_high <= 3'h0;
        end else begin
            cs_high <= cs_n_i ? (cs_high == 3'h7 ? cs_high : cs_high + 3'h1) : 3'h0;
        end
    end
    AST_OE_IDLE: assert property (cs_high == 3'h7 |-> !so_oe_o)
        else $error("serial output enabled while deselected");
    AST_ERASE_ALL: assert property (exec_o && chip |-> protect_level_o == 4'h0)
        else $error("chip erase ran with protection set");
    AST_EXEC_LATCH: assert property (exec_o |-> $past(write_enable_latch_o))
        else $error("change ran without write enable");
    AST_LATCH_DROP: assert property (exec_o |-> ##2 !write_enable_latch_o)
        else $error("write enable kept after change");
    AST_OTP_NO_ARRAY: assert property (exec_o && otp_mode_o |-> !chip && exec_cmd_o == flash_guard_pkg::PAGE_PROG_CMD)
        else $error("array change in otp mode");
    AST_BUSY_HOLD: assert property (exec_o |-> !$past(busy_i))
        else $error("change ran while busy");
    AST_PROTECT: assert property (exec_o && !otp_mode_o && !chip |-> !hit)
        else $error("change ran on guarded block");
    AST_LOCK_KEEP: assert property (customer_lock_o |=> customer_lock_o)
        else $error("customer lock dropped");
    cover property (exec_o && chip);
    cover property (exec_o && otp_mode_o);
    cover property ($rose(customer_lock_o));
endmodule : flash_guard_checker

bind flash_guard flash_guard_checker i_flash_guard_checker (.*);

// >>> tb/tb.sv
// Self-checking bench: serial host frames against the flash guard.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, cs_n, sclk, si, so, so_oe, wp_n, quad, tbs, busy, flock;
    logic strobe, exec, rej, cust, otp;
    logic [7:0] rd_data;
    logic [23:0] rd_addr;
    logic [3:0] lvl;
    logic [55:0] rx;
    logic [3:0] lv [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9};
    int errors = 0;
    int n_checks = 0;
    int n_exec, n_rej, oe_seen, cycles = 0;
    flash_guard i_flash_guard (
        .clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .so_o(so),
        .so_oe_o(so_oe), .wp_n_i(wp_n), .quad_mode_i(quad), .top_bottom_select_i(tbs),
        .busy_i(busy), .factory_lock_i(flock), .rd_data_i(rd_data), .rd_strobe_o(strobe),
        .rd_addr_o(rd_addr), .wr_byte_o(), .wr_data_o(), .exec_o(exec), .exec_cmd_o(),
        .exec_addr_o(), .reject_o(rej), .protect_level_o(lvl), .guard_bit_o(),
        .write_enable_latch_o(), .customer_lock_o(cust), .otp_mode_o(otp)
    );
    spi_host i_spi_host (.clk_i(clk), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Array byte mirrors its address, so stream order is visible; hang guard counts cycles
    always @(posedge clk) begin
        rd_data <= (strobe === 1'b1) ? rd_addr[7:0] ^ 8'hA5 : rd_data;
        cycles++;
        n_exec += int'(exec === 1'b1);
        n_rej += int'(rej === 1'b1);
        oe_seen += int'(so_oe === 1'b1);
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    function automatic bit guarded(logic [3:0] l, bit t, int b);
        int n = l > 4'h3 ? 8 : (l == 4'h3 ? 4 : int'(l));
        return t ? b < n : b >= 8 - n;
    endfunction : guarded
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check
    task automatic cmd(input logic [55:0] b, input int nb);
        n_exec = 0;
        n_rej = 0;
        oe_seen = 0;
        i_spi_host.frame(b, nb, rx);
    endtask : cmd
    task automatic wen();
        cmd({8'h06, 48'h0}, 8);
    endtask : wen
    task automatic outcome(input bit acc, input string what);
        check(n_exec * 2 + n_rej, acc ? 2 : 1, what);
    endtask : outcome
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        {rst_n, wp_n, quad, tbs, busy, flock} = 6'b010001;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        // Levels 0-4 and 9, both directions, every block, then whole-chip erase
        foreach (lv[i]) begin
            for (int t = 0; t < 2; t++) begin
                tbs = t[0];
                wen();
                cmd({8'h01, 2'b00, lv[i], 2'b00, 40'h0}, 16);
                cmd({8'h05, 48'h0}, 16);
                check(rx[5:2], lv[i], "level");
                for (int b = 0; b < 8; b++) begin
                    wen();
                    cmd({8'hD8, 5'h10, b[2:0], 16'h1234, 24'h0}, 32);
                    outcome(!guarded(lv[i], t[0], b), "erase");
                end
                wen();
                cmd({8'h60, 48'h0}, 8);
                outcome(lv[i] == 4'h0, "chip");
            end
        end
        $display("test protect done");
        wen();
        cmd({8'h01, 48'h0}, 16);
        cmd({8'h20, 48'h0}, 32);
        outcome(0, "no latch");
        cmd({8'h06, 48'h0}, 11);
        cmd({8'h05, 48'h0}, 16);
        check(rx[1], 1'b0, "cut frame");
        busy = 1'b1;
        wen();
        cmd({8'h20, 48'h0}, 32);
        outcome(0, "busy");
        busy = 1'b0;
        $display("test framing done");
        cmd({8'h0B, 48'h0}, 48);
        check(oe_seen, 0, "unknown");
        i_spi_host.mode3 = 1'b1;
        cmd({8'h03, 24'hF7FFFF, 24'h0}, 48);
        check(rx[15:0], 16'h5AA5, "read");
        check(oe_seen > 0, 1, "active");
        $display("test read done");
        cmd({8'hB1, 48'h0}, 8);
        check(otp, 1'b1, "otp on");
        for (int k = 0; k < 3; k++) begin
            wen();
            cmd({k == 2 ? 8'hD8 : 8'h02, 14'h0, k[0], 9'h010, 8'h5C, 16'h0}, k == 2 ? 32 : 40);
            outcome(k == 0, "otp row");
        end
        cmd({8'hC1, 48'h0}, 8);
        wen();
        cmd({8'h2F, 48'h0}, 8);
        cmd({8'h2B, 48'h0}, 16);
        check(rx[7:0], 8'h03, "security");
        cmd({8'hB1, 48'h0}, 8);
        wen();
        cmd({8'h02, 24'h000010, 8'h5C, 16'h0}, 40);
        outcome(0, "locked");
        cmd({8'hC1, 48'h0}, 8);
        check(otp, 1'b0, "otp off");
        $display("test otp done");
        wen();
        cmd({8'h01, 8'h80, 40'h0}, 16);
        cmd({8'h05, 48'h0}, 16);
        check(rx[7], 1'b1, "guard bit");
        wp_n = 1'b0;
        for (int q = 0; q < 2; q++) begin
            quad = q[0];
            wen();
            cmd({8'h01, 8'h04, 40'h0}, 16);
            check(lvl, q ? 4'h1 : 4'h0, "pin guard");
        end
        $display("test pin guard done");
        tally_and_finish();
    end
endmodule : tb
